/* rtl/radio_frame_control_pkg.sv */
// constants, register map and carrier types of the radio frame control registers
package radio_frame_control_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS         = 50;
  localparam int SYMBOL_TIME_NS          = 16000;
  localparam int POST_RX_TIMEOUT_SYMBOLS = 12;
  localparam int POST_RX_TIMEOUT_CYCLES  =
    POST_RX_TIMEOUT_SYMBOLS * SYMBOL_TIME_NS / CLOCK_PERIOD_NS;
  localparam int TIMER_WIDTH             = 12;

  // ---------------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [15:0] IDX_DAC_OVERRIDE_LOW          = 16'hDF3D;
  localparam logic [15:0] IDX_EXT_ADDRESS_BYTE0         = 16'hDF43;
  localparam logic [15:0] IDX_EXT_ADDRESS_BYTE1         = 16'hDF44;
  localparam logic [15:0] IDX_EXT_ADDRESS_BYTE2         = 16'hDF45;
  localparam logic [15:0] IDX_EXT_ADDRESS_BYTE3         = 16'hDF46;
  localparam logic [15:0] IDX_EXT_ADDRESS_BYTE4         = 16'hDF47;
  localparam logic [15:0] IDX_EXT_ADDRESS_BYTE5         = 16'hDF48;
  localparam logic [15:0] IDX_EXT_ADDRESS_BYTE6         = 16'hDF49;
  localparam logic [15:0] IDX_EXT_ADDRESS_BYTE7         = 16'hDF4A;
  localparam logic [15:0] IDX_NETWORK_ID_HIGH           = 16'hDF4B;
  localparam logic [15:0] IDX_NETWORK_ID_LOW            = 16'hDF4C;
  localparam logic [15:0] IDX_NODE_SHORT_ADDR_HIGH      = 16'hDF4D;
  localparam logic [15:0] IDX_NODE_SHORT_ADDR_LOW       = 16'hDF4E;
  localparam logic [15:0] IDX_RX_THRESHOLD_CONFIG       = 16'hDF4F;
  localparam logic [15:0] IDX_CHANNEL_CLEAR_PIN_CONFIG  = 16'hDF50;
  localparam logic [15:0] IDX_FRAME_DELIM_PIN_CONFIG    = 16'hDF51;
  localparam logic [15:0] IDX_RX_FLAGS_DEBUG_PIN_CONFIG = 16'hDF52;
  localparam logic [15:0] IDX_RX_BUFFER_BYTE_COUNT      = 16'hDF53;
  localparam logic [15:0] IDX_FRAME_SM_CONTROL          = 16'hDF54;

  // ---------------------------------------------------------------------------
  // storage slots, in index order
  // ---------------------------------------------------------------------------
  localparam int NUM_SLOTS        = 19;
  localparam int SLOT_DAC         = 0;
  localparam int SLOT_EXT0        = 1;
  localparam int SLOT_NETID_HIGH  = 9;
  localparam int SLOT_NETID_LOW   = 10;
  localparam int SLOT_SHORT_HIGH  = 11;
  localparam int SLOT_SHORT_LOW   = 12;
  localparam int SLOT_RX_THR      = 13;
  localparam int SLOT_CCA_CFG     = 14;
  localparam int SLOT_SFD_CFG     = 15;
  localparam int SLOT_FLAGS_CFG   = 16;
  localparam int SLOT_RX_COUNT    = 17;
  localparam int SLOT_FSM_CTRL    = 18;

  localparam logic [15:0] SLOT_INDEX [NUM_SLOTS] = '{
    IDX_DAC_OVERRIDE_LOW, IDX_EXT_ADDRESS_BYTE0, IDX_EXT_ADDRESS_BYTE1,
    IDX_EXT_ADDRESS_BYTE2, IDX_EXT_ADDRESS_BYTE3, IDX_EXT_ADDRESS_BYTE4,
    IDX_EXT_ADDRESS_BYTE5, IDX_EXT_ADDRESS_BYTE6, IDX_EXT_ADDRESS_BYTE7,
    IDX_NETWORK_ID_HIGH, IDX_NETWORK_ID_LOW, IDX_NODE_SHORT_ADDR_HIGH,
    IDX_NODE_SHORT_ADDR_LOW, IDX_RX_THRESHOLD_CONFIG, IDX_CHANNEL_CLEAR_PIN_CONFIG,
    IDX_FRAME_DELIM_PIN_CONFIG, IDX_RX_FLAGS_DEBUG_PIN_CONFIG,
    IDX_RX_BUFFER_BYTE_COUNT, IDX_FRAME_SM_CONTROL};

  // writable bits; everything else is reserved or hardware owned
  localparam logic [7:0] SLOT_WRITE_MASK [NUM_SLOTS] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'h3F, 8'h00, 8'h2F};

  localparam logic [7:0] RX_THR_RESET   = 8'h40;
  localparam logic [7:0] FSM_CTRL_RESET = 8'h21;
  localparam logic [7:0] SLOT_RESET [NUM_SLOTS] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, RX_THR_RESET, 8'h00, 8'h00, 8'h00, 8'h00,
    FSM_CTRL_RESET};

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int DAC_I_MSB         = 7;
  localparam int DAC_I_LSB         = 6;
  localparam int DAC_Q_MSB         = 5;
  localparam int DAC_Q_LSB         = 0;
  localparam int RX_THR_MSB        = 6;
  localparam int PIN_OE_BIT        = 6;
  localparam int PIN_INVERT_BIT    = 5;
  localparam int PIN_SEL_MSB       = 4;
  localparam int PIN_SEL_LSB       = 0;
  localparam logic [4:0] PIN_SEL_STATUS = 5'h00;
  localparam int DEBUG_SRC_MSB     = 5;
  localparam int DEBUG_SRC_LSB     = 4;
  localparam int THR_OE_BIT        = 3;
  localparam int THR_INVERT_BIT    = 2;
  localparam int AVAIL_OE_BIT      = 1;
  localparam int AVAIL_INVERT_BIT  = 0;
  localparam int ABORT_RX_BIT      = 5;
  localparam int RX_INTERRUPTED_BIT = 4;
  localparam int NO_TURNAROUND_BIT = 3;
  localparam int NO_TIMEOUT_BIT    = 2;
  localparam int PENDING_OR_BIT    = 1;
  localparam int ACCEPT_ACK_BIT    = 0;
  localparam logic [2:0] TX_CONV_SRC_OVERRIDE = 3'h1;

  // port 1 pin lanes of pinOut / pinOutEn
  localparam int LANE_P1_7 = 3;
  localparam int LANE_P1_6 = 2;
  localparam int LANE_P1_5 = 1;
  localparam int LANE_P1_4 = 0;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DEBUG_OFF,
    DEBUG_GAIN_STATUS,
    DEBUG_RAW_IQ,
    DEBUG_FILTERED_IQ
  } debug_source_t;

  typedef struct packed {
    logic [63:0] extAddress;
    logic [15:0] networkId;
    logic [15:0] shortAddr;
  } filter_ids_t;

  typedef struct packed {
    logic       channelClear;
    logic       frameDelim;
    logic       frameComplete;
    logic       rxActive;
    logic       rxEnded;
    logic       receiveOnStrobe;
    logic       commandStrobe;
    logic       txDone;
    logic       controllerPending;
    logic [7:0] byteCount;
  } radio_status_t;

endpackage : radio_frame_control_pkg

/* rtl/radio_frame_control_regs.sv */
// apb register bank and status pin routing of the radio frame controller
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps

module radio_frame_control_regs (
  input  wire logic                                  clock,
  input  wire logic                                  resetn,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [31:0]                           paddr,
  input  wire logic [31:0]                           pwdata,
  output logic                                       pready,
  output logic [31:0]                                prdata,
  output logic                                       pslverr,
  input  wire radio_frame_control_pkg::radio_status_t radioStatus,
  input  wire logic [2:0]                            txConvSourceSelect,
  output radio_frame_control_pkg::filter_ids_t       filterIds,
  output logic [3:0]                                 pinOut,
  output logic [3:0]                                 pinOutEn,
  output radio_frame_control_pkg::debug_source_t     debugSerialSource,
  output logic [1:0]                                 dacOverrideI,
  output logic [5:0]                                 dacOverrideQ,
  output logic                                       dacOverrideValid,
  output logic                                       abortRx,
  output logic                                       autoRxStart,
  output logic                                       postRxTimeout,
  output logic                                       modulatorPending,
  output logic                                       acceptAcknowledgeFrames
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  localparam int NS = radio_frame_control_pkg::NUM_SLOTS;

  typedef enum {
    TIMER_IDLE,
    TIMER_RUN
  } timer_state_t;

  logic [7:0]                                 regStore [NS];
  logic [NS-1:0]                              slotHit;
  logic                                       anyHit;
  logic                                       setupPhase;
  logic                                       writeTaken;
  logic [7:0]                                 readByte;
  logic                                       rxInterrupted;
  logic                                       interruptHit;
  logic                                       rxThresholdFlag;
  logic                                       rxAvailableFlag;
  logic                                       channelClearPinOk;
  logic                                       frameDelimPinOk;
  logic [radio_frame_control_pkg::TIMER_WIDTH-1:0] timeoutCount;
  timer_state_t                               timerState;
  logic [7:0]                                 ccaCfg;
  logic [7:0]                                 sfdCfg;
  logic [7:0]                                 flagsCfg;
  logic [7:0]                                 fsmCfg;

  assign ccaCfg   = regStore[radio_frame_control_pkg::SLOT_CCA_CFG];
  assign sfdCfg   = regStore[radio_frame_control_pkg::SLOT_SFD_CFG];
  assign flagsCfg = regStore[radio_frame_control_pkg::SLOT_FLAGS_CFG];
  assign fsmCfg   = regStore[radio_frame_control_pkg::SLOT_FSM_CTRL];

  // ---------------------------------------------------------------------------
  // apb decode and register storage
  // ---------------------------------------------------------------------------
  assign setupPhase = psel & ~penable;
  assign writeTaken = psel & penable & pready & pwrite & anyHit;
  assign anyHit     = |slotHit;

  genvar s;
  generate
    for (s = 0; s < NS; s++) begin : gSlot
      assign slotHit[s] =
        (paddr == {14'h0000, radio_frame_control_pkg::SLOT_INDEX[s], 2'b00});
      // only writable bits are stored, so reserved bits stay zero
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          regStore[s] <= radio_frame_control_pkg::SLOT_RESET[s];
        end else if (writeTaken && slotHit[s]) begin
          regStore[s] <= pwdata[7:0] & radio_frame_control_pkg::SLOT_WRITE_MASK[s];
        end
      end
    end
  endgenerate

  always_comb begin
    readByte = 8'h00;
    for (int i = 0; i < NS; i++) begin
      if (slotHit[i]) begin
        readByte = readByte | regStore[i];
      end
    end
    if (slotHit[radio_frame_control_pkg::SLOT_RX_COUNT]) begin
      readByte = radioStatus.byteCount;
    end
    if (slotHit[radio_frame_control_pkg::SLOT_FSM_CTRL]) begin
      readByte[radio_frame_control_pkg::RX_INTERRUPTED_BIT] = rxInterrupted;
    end
  end

  // one access cycle: ready is raised for the cycle after every setup
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase & ~anyHit;
      if (setupPhase) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // identifiers for frame filtering
  // ---------------------------------------------------------------------------
  // bytes come straight from storage flops
  assign filterIds.extAddress = {
    regStore[radio_frame_control_pkg::SLOT_EXT0 + 7],
    regStore[radio_frame_control_pkg::SLOT_EXT0 + 6],
    regStore[radio_frame_control_pkg::SLOT_EXT0 + 5],
    regStore[radio_frame_control_pkg::SLOT_EXT0 + 4],
    regStore[radio_frame_control_pkg::SLOT_EXT0 + 3],
    regStore[radio_frame_control_pkg::SLOT_EXT0 + 2],
    regStore[radio_frame_control_pkg::SLOT_EXT0 + 1],
    regStore[radio_frame_control_pkg::SLOT_EXT0]};
  assign filterIds.networkId = {
    regStore[radio_frame_control_pkg::SLOT_NETID_HIGH],
    regStore[radio_frame_control_pkg::SLOT_NETID_LOW]};
  assign filterIds.shortAddr = {
    regStore[radio_frame_control_pkg::SLOT_SHORT_HIGH],
    regStore[radio_frame_control_pkg::SLOT_SHORT_LOW]};

  // ---------------------------------------------------------------------------
  // status pin routing
  // ---------------------------------------------------------------------------
  // the flag compares against the stored level, so a level of 127 still works
  assign rxThresholdFlag = (radioStatus.byteCount >
    {1'b0, regStore[radio_frame_control_pkg::SLOT_RX_THR][radio_frame_control_pkg::RX_THR_MSB:0]})
    | radioStatus.frameComplete;
  assign rxAvailableFlag = (radioStatus.byteCount != 8'h00);

  // a nonzero select clears the output enable, so the status is not driven out
  assign channelClearPinOk = ccaCfg[radio_frame_control_pkg::PIN_OE_BIT] &
    (ccaCfg[radio_frame_control_pkg::PIN_SEL_MSB:radio_frame_control_pkg::PIN_SEL_LSB]
     == radio_frame_control_pkg::PIN_SEL_STATUS);
  assign frameDelimPinOk = sfdCfg[radio_frame_control_pkg::PIN_OE_BIT] &
    (sfdCfg[radio_frame_control_pkg::PIN_SEL_MSB:radio_frame_control_pkg::PIN_SEL_LSB]
     == radio_frame_control_pkg::PIN_SEL_STATUS);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinOut   <= 4'h0;
      pinOutEn <= 4'h0;
    end else begin
      pinOutEn[radio_frame_control_pkg::LANE_P1_7] <= channelClearPinOk;
      pinOut[radio_frame_control_pkg::LANE_P1_7] <= radioStatus.channelClear
        ^ ccaCfg[radio_frame_control_pkg::PIN_INVERT_BIT];
      pinOutEn[radio_frame_control_pkg::LANE_P1_6] <= frameDelimPinOk;
      pinOut[radio_frame_control_pkg::LANE_P1_6] <= radioStatus.frameDelim
        ^ sfdCfg[radio_frame_control_pkg::PIN_INVERT_BIT];
      pinOutEn[radio_frame_control_pkg::LANE_P1_5] <=
        flagsCfg[radio_frame_control_pkg::THR_OE_BIT];
      pinOut[radio_frame_control_pkg::LANE_P1_5] <= rxThresholdFlag
        ^ flagsCfg[radio_frame_control_pkg::THR_INVERT_BIT];
      pinOutEn[radio_frame_control_pkg::LANE_P1_4] <=
        flagsCfg[radio_frame_control_pkg::AVAIL_OE_BIT];
      pinOut[radio_frame_control_pkg::LANE_P1_4] <= rxAvailableFlag
        ^ flagsCfg[radio_frame_control_pkg::AVAIL_INVERT_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // debug source and converter override
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      debugSerialSource <= radio_frame_control_pkg::DEBUG_OFF;
    end else begin
      debugSerialSource <= radio_frame_control_pkg::debug_source_t'(
        flagsCfg[radio_frame_control_pkg::DEBUG_SRC_MSB:radio_frame_control_pkg::DEBUG_SRC_LSB]
      );
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dacOverrideI     <= 2'h0;
      dacOverrideQ     <= 6'h00;
      dacOverrideValid <= 1'b0;
    end else begin
      dacOverrideI <= regStore[radio_frame_control_pkg::SLOT_DAC]
        [radio_frame_control_pkg::DAC_I_MSB:radio_frame_control_pkg::DAC_I_LSB];
      dacOverrideQ <= regStore[radio_frame_control_pkg::SLOT_DAC]
        [radio_frame_control_pkg::DAC_Q_MSB:radio_frame_control_pkg::DAC_Q_LSB];
      dacOverrideValid <=
        (txConvSourceSelect == radio_frame_control_pkg::TX_CONV_SRC_OVERRIDE);
    end
  end

  // ---------------------------------------------------------------------------
  // frame state machine controls
  // ---------------------------------------------------------------------------
  // a receive-on strobe with abort disabled lets reception continue
  assign interruptHit = radioStatus.commandStrobe & radioStatus.rxActive &
    ~(radioStatus.receiveOnStrobe & ~fsmCfg[radio_frame_control_pkg::ABORT_RX_BIT]);

  // set wins over the clear of a strobe arriving in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxInterrupted <= 1'b0;
    end else if (interruptHit) begin
      rxInterrupted <= 1'b1;
    end else if (radioStatus.commandStrobe) begin
      rxInterrupted <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      abortRx                 <= 1'b0;
      autoRxStart             <= 1'b0;
      modulatorPending        <= 1'b0;
      acceptAcknowledgeFrames <= 1'b1;
    end else begin
      abortRx <= radioStatus.receiveOnStrobe & radioStatus.rxActive
        & fsmCfg[radio_frame_control_pkg::ABORT_RX_BIT];
      autoRxStart <= radioStatus.txDone
        & ~fsmCfg[radio_frame_control_pkg::NO_TURNAROUND_BIT];
      modulatorPending <= radioStatus.controllerPending
        | fsmCfg[radio_frame_control_pkg::PENDING_OR_BIT];
      acceptAcknowledgeFrames <= fsmCfg[radio_frame_control_pkg::ACCEPT_ACK_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // post-reception timeout
  // ---------------------------------------------------------------------------
  // a new reception or the disable bit cancels a running timeout
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timerState    <= TIMER_IDLE;
      timeoutCount  <= '0;
      postRxTimeout <= 1'b0;
    end else begin
      postRxTimeout <= 1'b0;
      unique case (timerState)
        TIMER_IDLE: begin
          if (radioStatus.rxEnded && !fsmCfg[radio_frame_control_pkg::NO_TIMEOUT_BIT]) begin
            timerState   <= TIMER_RUN;
            timeoutCount <= radio_frame_control_pkg::TIMER_WIDTH'(
              radio_frame_control_pkg::POST_RX_TIMEOUT_CYCLES - 1);
          end
        end
        TIMER_RUN: begin
          if (fsmCfg[radio_frame_control_pkg::NO_TIMEOUT_BIT] || radioStatus.rxActive) begin
            timerState <= TIMER_IDLE;
          end else if (timeoutCount == '0) begin
            timerState    <= TIMER_IDLE;
            postRxTimeout <= 1'b1;
          end else begin
            timeoutCount <= timeoutCount - 1'b1;
          end
        end
      endcase
    end
  end

endmodule : radio_frame_control_regs

/* verif/radio_frame_control_checker.sv */
// concurrent checks on the ports of the radio frame control registers
`timescale 1ns/100ps
module radio_frame_control_checker (
  input wire logic                                   clock,
  input wire logic                                   resetn,
  input wire logic                                   psel,
  input wire logic                                   penable,
  input wire logic                                   pwrite,
  input wire logic                                   pready,
  input wire logic                                   pslverr,
  input wire logic [31:0]                            prdata,
  input wire radio_frame_control_pkg::radio_status_t radioStatus,
  input wire logic [2:0]                             txConvSourceSelect,
  input wire logic                                   dacOverrideValid,
  input wire logic                                   abortRx,
  input wire logic                                   autoRxStart,
  input wire logic                                   postRxTimeout,
  input wire logic                                   modulatorPending,
  input wire logic                                   acceptAcknowledgeFrames
);
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
  property p_high; pready |-> prdata[31:8] == 24'h000000; endproperty
  property p_err; pready && pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
  property p_ack; $rose(resetn) |-> acceptAcknowledgeFrames; endproperty
  property p_valid; dacOverrideValid == $past(txConvSourceSelect == 3'h1); endproperty
  property p_pend; $past(radioStatus.controllerPending) |-> modulatorPending; endproperty
  property p_abort;
    abortRx |-> $past(radioStatus.receiveOnStrobe && radioStatus.rxActive);
  endproperty
  property p_auto; autoRxStart |-> $past(radioStatus.txDone); endproperty
  // a new reception cancels the timer, so no pulse may follow an active cycle
  property p_tmo; postRxTimeout |-> !$past(radioStatus.rxActive); endproperty
  a_ready: assert property (p_ready) else $error("pready not a one-cycle answer");
  a_high: assert property (p_high) else $error("read data upper bits set");
  a_err: assert property (p_err) else $error("unmapped read not zero");
  a_ack: assert property (p_ack) else $error("ack accept not one after reset");
  a_valid: assert property (p_valid) else $error("override valid wrong");
  a_pend: assert property (p_pend) else $error("pending not passed on");
  a_abort: assert property (p_abort) else $error("abort without cause");
  a_auto: assert property (p_auto) else $error("auto receive without tx end");
  a_tmo: assert property (p_tmo) else $error("timeout during reception");
  c_abort: cover property (abortRx);
  c_tmo: cover property (postRxTimeout);
  c_err: cover property (pready && pslverr);
endmodule : radio_frame_control_checker
bind radio_frame_control_regs radio_frame_control_checker u_chk (.clock, .resetn, .psel,
  .penable, .pwrite, .pready, .pslverr, .prdata, .radioStatus, .txConvSourceSelect,
  .dacOverrideValid, .abortRx, .autoRxStart, .postRxTimeout, .modulatorPending,
  .acceptAcknowledgeFrames);

/* verif/tb.sv */
// self-checking bench of the radio frame control registers
`timescale 1ns/100ps
module tb;
  logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [2:0]  cs = 3'h0;
  logic [3:0]  po, pe;
  logic [1:0]  di;
  logic [5:0]  dq;
  logic        dv, ab, au, tm, mp, ak;
  int          failures = 0, checks = 0;
  radio_frame_control_pkg::radio_status_t st = '0;
  radio_frame_control_pkg::filter_ids_t   ids;
  radio_frame_control_pkg::debug_source_t dbg;
  radio_frame_control_regs dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .radioStatus(st), .txConvSourceSelect(cs), .filterIds(ids),
    .pinOut(po), .pinOutEn(pe), .debugSerialSource(dbg), .dacOverrideI(di),
    .dacOverrideQ(dq), .dacOverrideValid(dv), .abortRx(ab), .autoRxStart(au),
    .postRxTimeout(tm), .modulatorPending(mp), .acceptAcknowledgeFrames(ak));
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  initial forever #25 clock = ~clock;
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // setup then access; waits for pready, takes data and error at that edge
  task automatic apb(input logic w, input int s, input logic [7:0] d, input logic [15:0] a = 0);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0000, (s < 0) ? a : radio_frame_control_pkg::SLOT_INDEX[s], 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // no cycle count is assumed; only the watchdog ends a stalled wait
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tick();
    repeat (2) @(posedge clock);
    #1;
  endtask : tick
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic tMap();
    for (int i = 0; i < 19; i++) begin
      apb(0, i, 8'h00);
      chk("reset", rd, (i == 13) ? 32'h40 : (i == 18) ? 32'h21 : 32'h0);
      apb(1, i, 8'hFF);
      apb(0, i, 8'h00);
      chk("mask", rd, (i < 13) ? 32'hFF : (i == 16) ? 32'h3F : (i == 17) ? 32'h0 :
        (i == 18) ? 32'h2F : 32'h7F);
    end
    apb(0, -1, 8'h00, 16'h0100);
    chk("unmapped", {er, rd}, 64'h100000000);
    for (int i = 1; i < 13; i++) apb(1, i, 8'(i));
    apb(1, 0, 8'hC5);
    cs <= 3'h1;
    tick();
    chk("extAddress", ids.extAddress, 64'h0807060504030201);
    chk("idShort", {ids.networkId, ids.shortAddr}, 64'h090A0B0C);
    chk("dac", {dv, di, dq}, 64'h1C5);
    @(posedge clock);
    cs <= 3'h2;
    tick();
    chk("dacOff", dv, 1'b0);
    $display("tMap done");
  endtask : tMap
  task automatic tPins();
    @(posedge clock);
    st.channelClear <= 1'b1;
    st.frameDelim <= 1'b1;
    st.byteCount <= 8'h05;
    apb(1, 14, 8'h40);
    apb(1, 15, 8'h60);
    apb(1, 13, 8'h04);
    apb(1, 16, 8'h0E);
    tick();
    chk("p17p16", {pe[3:2], po[3:2]}, 4'hE);
    chk("p15p14", {pe[1:0], po[1:0]}, 4'hD);
    apb(0, 17, 8'h00);
    chk("count", rd, 32'h05);
    apb(1, 14, 8'h61);
    apb(1, 15, 8'h20);
    st.byteCount <= 8'h04;
    st.frameComplete <= 1'b1;
    tick();
    chk("selOff", pe[3:2], 2'h0);
    chk("frameDone", po[1], 1'b0);
    for (int d = 0; d < 4; d++) begin
      apb(1, 16, 8'(d << 4));
      tick();
      chk("debug", dbg, d);
    end
    chk("flagsOff", pe[1:0], 2'h0);
    $display("tPins done");
  endtask : tPins
  task automatic tFsm();
    int n;
    for (int k = 0; k < 2; k++) begin
      apb(1, 18, k ? 8'h03 : 8'h21);
      st.rxActive <= 1'b1;
      st.receiveOnStrobe <= 1'b1;
      st.commandStrobe <= 1'b1;
      @(posedge clock);
      st.receiveOnStrobe <= 1'b0;
      st.commandStrobe <= 1'b0;
      #1 chk("abort", ab, !k);
      apb(0, 18, 8'h00);
      chk("interrupted", rd[4], !k);
    end
    st.rxActive <= 1'b0;
    st.commandStrobe <= 1'b1;
    @(posedge clock);
    st.commandStrobe <= 1'b0;
    apb(0, 18, 8'h00);
    chk("cleared", rd, 32'h03);
    for (int k = 0; k < 2; k++) begin
      apb(1, 18, k ? 8'h09 : 8'h02);
      st.txDone <= 1'b1;
      st.controllerPending <= (k != 0);
      @(posedge clock);
      st.txDone <= 1'b0;
      #1 chk("autoRx", {au, mp, ak}, k ? 3'h3 : 3'h6);
    end
    for (int k = 0; k < 2; k++) begin
      apb(1, 18, k ? 8'h25 : 8'h21);
      n = 0;
      st.rxEnded <= 1'b1;
      @(posedge clock);
      st.rxEnded <= 1'b0;
      while (tm !== 1'b1 && n < 4000) begin
        @(posedge clock);
        n++;
      end
      chk("timeout", n > 3830 && n < 3850, !k);
    end
    $display("tFsm done");
  endtask : tFsm
  initial begin
    #2000000;
    failures++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    tMap();
    tPins();
    tFsm();
    conclude();
  end
endmodule : tb
